// File: verilog/pmr_pkg.sv
`default_nettype none
package pmr_pkg;

    localparam int unsigned REG_W     = 16;
    localparam int unsigned BYTE_W    = 8;
    localparam int unsigned NUM_RES   = 4;
    localparam int unsigned AVG_W     = 11;
    localparam int unsigned TIME_W    = 14;

    // command codes
    localparam logic [7:0] CMD_SETUP     = 8'h00;
    localparam logic [7:0] CMD_SENSE_RES = 8'h01;
    localparam logic [7:0] CMD_BUS_RES   = 8'h02;
    localparam logic [7:0] CMD_POWER_RES = 8'h03;
    localparam logic [7:0] CMD_CURR_RES  = 8'h04;
    localparam logic [7:0] CMD_SCALE     = 8'h05;
    localparam logic [7:0] CMD_ALERT_CFG = 8'h06;
    localparam logic [7:0] CMD_ALERT_LIM = 8'h07;
    localparam logic [7:0] CMD_MAKER     = 8'hfe;
    localparam logic [7:0] CMD_DIE       = 8'hff;

    // reset values
    localparam logic [15:0] SETUP_RST  = 16'h4127;
    localparam logic [15:0] ZERO_RST   = 16'h0000;

    // operating_setup field positions
    localparam int unsigned SOFT_RST_BIT  = 15;
    localparam int unsigned AVG_HI        = 11;
    localparam int unsigned AVG_LO        = 9;
    localparam int unsigned BUS_CT_HI     = 8;
    localparam int unsigned BUS_CT_LO     = 6;
    localparam int unsigned SENSE_CT_HI   = 5;
    localparam int unsigned SENSE_CT_LO   = 3;
    localparam int unsigned MODE_HI       = 2;
    localparam int unsigned MODE_LO       = 0;
    localparam int unsigned MODE_SENSE    = 0;
    localparam int unsigned MODE_BUS      = 1;
    localparam int unsigned MODE_CONT     = 2;

    // result selector codes for the loading port
    localparam logic [1:0] RES_SENSE = 2'h0;
    localparam logic [1:0] RES_BUS   = 2'h1;
    localparam logic [1:0] RES_POWER = 2'h2;
    localparam logic [1:0] RES_CURR  = 2'h3;

    // conversion times in microseconds, indexed by the 3-bit code
    localparam logic [7:0][TIME_W-1:0] CONV_TIME_US = {
        14'd8205, 14'd4109, 14'd2061, 14'd1037, 14'd525, 14'd269, 14'd203, 14'd139};
    // averaged sample counts, indexed by the 3-bit code
    localparam logic [7:0][AVG_W-1:0] AVG_SAMPLES = {
        11'd1024, 11'd512, 11'd256, 11'd128, 11'd64, 11'd16, 11'd4, 11'd1};

    typedef enum logic [1:0] {
        WR_CMD,
        WR_MSB,
        WR_LSB,
        WR_DONE
    } pmr_wr_state_t;

    typedef struct packed {
        logic              valid;
        logic [1:0]        sel;
        logic [REG_W-1:0]  data;
    } pmr_result_load_t;

    typedef struct packed {
        logic [AVG_W-1:0]  avgSamples;
        logic [TIME_W-1:0] busConvUs;
        logic [TIME_W-1:0] senseConvUs;
        logic              measureSense;
        logic              measureBus;
        logic              continuous;
        logic              shutdown;
    } pmr_setup_out_t;

endpackage : pmr_pkg
`default_nettype wire

// File: verilog/pmr_register_bank.sv
// Function
// - every register is 16 bits, moved as two bytes on the serial link
// - setup register at code 00h, reset value 4127h, read and write
// - read-only results at 01h..04h: sense, bus, power, current; reset 0000h
// - scale, alert setup and alert limit at 05h..07h, read and write, reset 0000h
// - read-only maker code at FEh and die code at FFh
// - reading the setup register changes nothing and leaves conversion running
// - setup write halts conversion until transfer ends, then restarts with new values
// - writing one to setup bit 15 restores all defaults; bit self-clears
// - setup bits 11:9 pick 1,4,16,64,128,256,512,1024 averaged samples
// - setup holds sense and bus conversion times, averaging and operating mode
// - bits 8:6 pick bus conversion time 139..8205 us, default 1037
// - bits 5:3 pick sense conversion time, same steps, default 1037
// - bits 2:0 mode: x00 shutdown, bit0 sense, bit1 bus, bit2 continuous
`timescale 1ns/1ns
`default_nettype none
module pmr_register_bank
    import pmr_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5a5a,  // arbitrary value
    parameter logic [15:0] DIE_CODE   = 16'ha5a5   // arbitrary value
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             xferStart,
    input  wire logic             xferStop,
    input  wire logic             wrValid,
    input  wire logic [7:0]       wrByte,
    input  wire logic             rdReq,
    output var  logic [7:0]       rdByte,
    input  wire pmr_result_load_t resLoad,
    output var  logic [15:0]      setupReg,
    output var  pmr_setup_out_t   setupOut,
    output var  logic [15:0]      scaleSetting,
    output var  logic [15:0]      alertSetup,
    output var  logic [15:0]      alertThreshold,
    output var  logic             convHalt,
    output var  logic             convStart
);

    typedef struct packed {
        logic [15:0]              setup;
        logic [NUM_RES-1:0][15:0] results;
        logic [15:0]              scale;
        logic [15:0]              alertCfg;
        logic [15:0]              alertLim;
        logic [7:0]               ptr;
        pmr_wr_state_t            wrState;
        logic [7:0]               msb;
        logic                     rdLow;
        logic [7:0]               rdByte;
        logic                     halt;
        logic                     setupWritten;
        logic                     start;
        pmr_setup_out_t           dec;
    } pmr_state_t;

    pmr_state_t stateQ;
    pmr_state_t stateD;

    // the byte engine and the read mux assume two whole bytes per register
    if (REG_W != 2 * BYTE_W || REG_W != 16) begin : g_bad_width
        $error("register width must be two bytes of eight bits");
    end
    // the result window spans four codes, one per result slot
    if (NUM_RES != 4) begin : g_bad_results
        $error("result slot count must be four");
    end

    function automatic logic [15:0] readMux(input pmr_state_t s);
        logic [15:0] v;
        v = ZERO_RST;
        if (s.ptr == CMD_SETUP) begin
            v = s.setup;
        end else if (s.ptr >= CMD_SENSE_RES && s.ptr <= CMD_CURR_RES) begin
            v = s.results[2'(s.ptr - CMD_SENSE_RES)];
        end else if (s.ptr == CMD_SCALE) begin
            v = s.scale;
        end else if (s.ptr == CMD_ALERT_CFG) begin
            v = s.alertCfg;
        end else if (s.ptr == CMD_ALERT_LIM) begin
            v = s.alertLim;
        end else if (s.ptr == CMD_MAKER) begin
            v = MAKER_CODE;
        end else if (s.ptr == CMD_DIE) begin
            v = DIE_CODE;
        end
        return v;
    endfunction : readMux

    function automatic pmr_setup_out_t decode(input logic [15:0] s);
        pmr_setup_out_t o;
        o.avgSamples   = AVG_SAMPLES[s[AVG_HI:AVG_LO]];
        o.busConvUs    = CONV_TIME_US[s[BUS_CT_HI:BUS_CT_LO]];
        o.senseConvUs  = CONV_TIME_US[s[SENSE_CT_HI:SENSE_CT_LO]];
        o.measureSense = s[MODE_LO + MODE_SENSE];
        o.measureBus   = s[MODE_LO + MODE_BUS];
        o.continuous   = s[MODE_LO + MODE_CONT];
        o.shutdown     = s[MODE_LO + MODE_BUS:MODE_LO] == 2'b00;
        return o;
    endfunction : decode

    always_comb begin
        logic [15:0] wrWord;
        logic        softRst;
        logic [15:0] rdWord;
        wrWord  = {stateQ.msb, wrByte};
        rdWord  = readMux(stateQ);
        softRst = 1'b0;
        stateD  = stateQ;
        stateD.start = 1'b0;

        // result loading from the conversion datapath
        if (resLoad.valid) begin
            stateD.results[resLoad.sel] = resLoad.data;
        end

        if (xferStart) begin
            stateD.wrState = WR_CMD;
            stateD.rdLow   = 1'b0;
        end else if (wrValid) begin
            case (stateQ.wrState)
                WR_CMD: begin
                    stateD.ptr     = wrByte;
                    stateD.wrState = WR_MSB;
                end
                WR_MSB: begin
                    stateD.msb     = wrByte;
                    stateD.wrState = WR_LSB;
                    if (stateQ.ptr == CMD_SETUP) begin
                        stateD.halt = 1'b1;
                    end
                end
                WR_LSB: begin
                    stateD.wrState = WR_DONE;
                    if (stateQ.ptr == CMD_SETUP) begin
                        if (wrWord[SOFT_RST_BIT]) begin
                            softRst = 1'b1;
                        end else begin
                            stateD.setup = wrWord;
                        end
                        stateD.setupWritten = 1'b1;
                    end else if (stateQ.ptr == CMD_SCALE) begin
                        stateD.scale = wrWord;
                    end else if (stateQ.ptr == CMD_ALERT_CFG) begin
                        stateD.alertCfg = wrWord;
                    end else if (stateQ.ptr == CMD_ALERT_LIM) begin
                        stateD.alertLim = wrWord;
                    end
                    // any other code is read-only or unmapped: dropped
                end
                default: begin
                    stateD.wrState = WR_DONE;                       // extra bytes ignored
                end
            endcase
        end

        // read bytes come out high first, then low
        if (rdReq) begin
            if (stateQ.rdLow) begin
                stateD.rdByte = rdWord[7:0];
            end else begin
                stateD.rdByte = rdWord[15:8];
            end
            stateD.rdLow  = ~stateQ.rdLow;
        end

        // restart only once the transfer is over so no conversion mixes settings
        if (xferStop) begin
            stateD.halt    = 1'b0;
            stateD.wrState = WR_CMD;
            if (stateQ.setupWritten || stateD.setupWritten) begin
                stateD.start        = 1'b1;
                stateD.setupWritten = 1'b0;
            end
        end

        // soft reset: bit 15 never stored, so it reads back zero
        if (softRst) begin
            stateD.setup    = SETUP_RST;
            stateD.results  = '0;
            stateD.scale    = ZERO_RST;
            stateD.alertCfg = ZERO_RST;
            stateD.alertLim = ZERO_RST;
        end

        stateD.dec = decode(stateD.setup);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stateQ.setup        <= SETUP_RST;
            stateQ.results      <= '0;
            stateQ.scale        <= ZERO_RST;
            stateQ.alertCfg     <= ZERO_RST;
            stateQ.alertLim     <= ZERO_RST;
            stateQ.ptr          <= CMD_SETUP;
            stateQ.wrState      <= WR_CMD;
            stateQ.msb          <= 8'h00;
            stateQ.rdLow        <= 1'b0;
            stateQ.rdByte       <= 8'h00;
            stateQ.halt         <= 1'b0;
            stateQ.setupWritten <= 1'b0;
            stateQ.start        <= 1'b0;
            stateQ.dec          <= decode(SETUP_RST);
        end else begin
            stateQ <= stateD;
        end
    end

    assign rdByte         = stateQ.rdByte;
    assign setupReg       = stateQ.setup;
    assign setupOut       = stateQ.dec;
    assign scaleSetting   = stateQ.scale;
    assign alertSetup     = stateQ.alertCfg;
    assign alertThreshold = stateQ.alertLim;
    assign convHalt       = stateQ.halt;
    assign convStart      = stateQ.start;

endmodule : pmr_register_bank
`default_nettype wire

// File: verif/pmr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmr_host_model
    import pmr_pkg::*;
(
    input  wire logic       ref_clk,
    output var  logic       xferStart,
    output var  logic       xferStop,
    output var  logic       wrValid,
    output var  logic [7:0] wrByte,
    output var  logic       rdReq,
    input  wire logic [7:0] rdByte
);
    initial {xferStart, wrValid, rdReq, xferStop, wrByte} = '0;
    // an idle byte lane toggles so stale data is never mistaken for a byte
    task automatic put(input logic [3:0] f, input logic [7:0] b);
        @(posedge ref_clk);
        #2;
        {xferStart, wrValid, rdReq, xferStop} = f;
        wrByte = f[2] ? b : ~wrByte;
    endtask : put
    task automatic wr_reg(input logic [7:0] c, input logic [15:0] d, input bit n);
        put(4'h8, 8'h00);
        put(4'h4, c);
        if (n) begin
            put(4'h4, d[15:8]);
            put(4'h4, d[7:0]);
        end
        put(4'h1, 8'h00);
        put(4'h0, 8'h00);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] c, output logic [15:0] d);
        wr_reg(c, 16'h0000, 1'b0);
        put(4'h8, 8'h00);
        put(4'h2, 8'h00);
        put(4'h2, 8'h00);
        d[15:8] = rdByte;
        put(4'h0, 8'h00);
        d[7:0] = rdByte;
    endtask : rd_reg
endmodule : pmr_host_model
`default_nettype wire

// File: verif/pmr_register_bank_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pmr_register_bank_chk
    import pmr_pkg::*;
(
    input wire logic           ref_clk,
    input wire logic           rst,
    input wire logic           xferStop,
    input wire logic           wrValid,
    input wire logic           rdReq,
    input wire logic [15:0]    setupReg,
    input wire pmr_setup_out_t setupOut,
    input wire logic [15:0]    scaleSetting,
    input wire logic           convHalt,
    input wire logic           convStart
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_rstVal;
        disable iff (1'b0) rst |=> setupReg == 16'h4127 && scaleSetting == 16'h0000;
    endproperty
    a_rstVal: assert property (p_rstVal) else $error("bad reset value");
    property p_selfClr;
        setupReg[15] == 1'b0;
    endproperty
    a_selfClr: assert property (p_selfClr) else $error("reset bit stuck");
    property p_restart;
        xferStop && convHalt |=> !convHalt && convStart ##1 !convStart;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_startCause;
        convStart |-> $past(xferStop) && $past(convHalt);
    endproperty
    a_startCause: assert property (p_startCause) else $error("stray start");
    property p_haltCause;
        $rose(convHalt) |-> $past(wrValid) && $past(wrValid, 2);
    endproperty
    a_haltCause: assert property (p_haltCause) else $error("stray halt");
    property p_readQuiet;
        rdReq && !convHalt |=> $stable(setupReg) && !convHalt;
    endproperty
    a_readQuiet: assert property (p_readQuiet) else $error("read disturbed");
    property p_mode;
        setupOut.measureSense == setupReg[0] && setupOut.measureBus == setupReg[1]
            && setupOut.continuous == setupReg[2] && setupOut.shutdown == (setupReg[1:0] == 2'b00);
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode");
    property p_busCt;
        setupReg[8:6] == 3'b100 |-> setupOut.busConvUs == 14'd1037;
    endproperty
    a_busCt: assert property (p_busCt) else $error("bus time");
    property p_senseCt;
        setupReg[5:3] == 3'b111 |-> setupOut.senseConvUs == 14'd8205;
    endproperty
    a_senseCt: assert property (p_senseCt) else $error("sense time");
    c_start: cover property (convStart);
    c_off: cover property (setupOut.shutdown);
    c_read: cover property (rdReq && !convHalt);
endmodule : pmr_register_bank_chk
bind pmr_register_bank pmr_register_bank_chk u_chk (.ref_clk, .rst, .xferStop, .wrValid,
    .rdReq, .setupReg, .setupOut, .scaleSetting, .convHalt, .convStart);
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected %0t got %h want %h", $time, a, b); end end
module tb_top
    import pmr_pkg::*;
;
    localparam logic [15:0] MK = 16'h3c3c;  // arbitrary value
    localparam logic [15:0] DI = 16'hc3c3;  // arbitrary value
    localparam int SAMPLE_AVERAGING_FIELD[8] = '{1, 4, 16, 64, 128, 256, 512, 1024};
    localparam int CT[8] = '{139, 203, 269, 525, 1037, 2061, 4109, 8205};
    logic ref_clk = 0, rst = 1, xferStart, xferStop, wrValid, rdReq, convHalt, convStart;
    logic [7:0] wrByte, rdByte;
    logic [15:0] setupReg, scaleSetting, alertSetup, alertThreshold, mem[8], v;
    pmr_result_load_t resLoad = '0;
    pmr_setup_out_t setupOut;
    int n_fail = 0, checks = 0;
    logic [7:0] codes[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'hfe, 8'hff, 8'h08};
    always #25 ref_clk = ~ref_clk;
    pmr_host_model host (.ref_clk, .xferStart, .xferStop, .wrValid, .wrByte, .rdReq, .rdByte);
    pmr_register_bank #(.MAKER_CODE(MK), .DIE_CODE(DI)) dut (.ref_clk, .rst, .xferStart,
        .xferStop, .wrValid, .wrByte, .rdReq, .rdByte, .resLoad, .setupReg, .setupOut,
        .scaleSetting, .alertSetup, .alertThreshold, .convHalt, .convStart);
    function automatic logic [15:0] expv(input logic [7:0] c);
        return c == 8'hfe ? MK : c == 8'hff ? DI : c < 8'h08 ? mem[c[2:0]] : 16'h0000;
    endfunction : expv
    task automatic defaults();
        foreach (mem[i]) mem[i] = (i == 0) ? 16'h4127 : 16'h0000;
    endtask : defaults
    task automatic chk_all();
        logic [15:0] d;
        foreach (codes[i]) begin
            host.rd_reg(codes[i], d);
            `CHK(d, expv(codes[i]))
        end
    endtask : chk_all
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h17d2f089));
        repeat (4) @(posedge ref_clk);
        #2 rst = 0;
        defaults();
        chk_all();
        $display("test reset done");
        foreach (codes[i]) begin
            v = 16'($urandom);
            host.wr_reg(codes[i] | 8'h01, v, 1'b1);
            if ((codes[i] | 8'h01) inside {8'h05, 8'h07}) mem[codes[i][2:0] | 3'h1] = v;
        end
        host.wr_reg(8'h06, 16'h0f0f, 1'b1);
        mem[6] = 16'h0f0f;
        chk_all();
        `CHK(alertSetup, 16'h0f0f)
        `CHK(scaleSetting, mem[5])
        `CHK(alertThreshold, mem[7])
        $display("test write access done");
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk);
            #2 resLoad = '{1'b1, 2'(s), 16'($urandom)};
            mem[s + 1] = resLoad.data;
        end
        @(posedge ref_clk);
        #2 resLoad = '0;
        chk_all();
        $display("test results done");
        for (int i = 0; i < 8; i++) begin
            v = {4'h0, 3'(i), 3'($urandom), 3'($urandom), 3'(i)};
            host.wr_reg(8'h00, v, 1'b1);
            `CHK(setupReg, v)
            `CHK(setupOut.avgSamples, 11'(SAMPLE_AVERAGING_FIELD[i]))
            `CHK(setupOut.busConvUs, 14'(CT[v[8:6]]))
            `CHK(setupOut.senseConvUs, 14'(CT[v[5:3]]))
            `CHK(setupOut.shutdown, 1'(i % 4 == 0))
            `CHK(setupOut.continuous, 1'(i / 4))
            `CHK(convHalt, 1'b0)
        end
        $display("test setup decode done");
        host.wr_reg(8'h00, 16'h8000 | 16'($urandom), 1'b1);
        defaults();
        `CHK(setupReg, 16'h4127)
        chk_all();
        $display("test soft reset done");
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
